// ==== ostm_cfg.svh ====
// Constants for the output-side sync timing monitor: offsets, field layouts, resets, timing.
// Assumes inclusion by bare name from the package and the monitor module.
`ifndef OSTM_CFG_SVH
`define OSTM_CFG_SVH

// Register byte offsets, one 32-bit word each
`define OSTM_ADDR_SYNC_MODE    8'h00
`define OSTM_ADDR_CAPS         8'h04
`define OSTM_ADDR_SHIFT        8'h08
`define OSTM_ADDR_MIN_CYCLE    8'h0C
`define OSTM_ADDR_CALC_COPY    8'h10
`define OSTM_ADDR_MIN_DELAY    8'h14
`define OSTM_ADDR_COMMAND      8'h18
`define OSTM_ADDR_MAX_DELAY    8'h1C
`define OSTM_ADDR_MISSED       8'h20
`define OSTM_ADDR_OVERRUN      8'h24
`define OSTM_ADDR_SHORT        8'h28
`define OSTM_ADDR_SYNC_ERR     8'h2C
`define OSTM_ADDR_IRQ_STATUS   8'h30
`define OSTM_ADDR_IRQ_MASK     8'h34

// Capability word: bits 0,1 free run and buffer-manager sync, 2-3 = 01, 4-5 = 10, 14 = 1
`define OSTM_CAPS_VALUE        16'h4027

// Reset values
`define OSTM_RST_SYNC_MODE     2'h1
`define OSTM_RST_MIN_CYCLE     32'h0003_D090
`define OSTM_RST_MEAS          32'h0000_0000
`define OSTM_RST_COMMAND       16'h0000
`define OSTM_RST_COUNT         16'h0000

// Sync mode encodings
`define OSTM_MODE_FREE_RUN     2'h0
`define OSTM_MODE_BM_EVENT     2'h1
`define OSTM_MODE_FIRST_SYNC   2'h2
`define OSTM_MODE_SECOND_SYNC  2'h3

// Status / mask bit positions
`define OSTM_EVT_MISSED        0
`define OSTM_EVT_OVERRUN       1
`define OSTM_EVT_SHORT         2
`define OSTM_EVT_SYNC_ERR      3

// Timing: clock rate and derived nanoseconds per clock
`define OSTM_CLK_FREQ_HZ       25000000
`define OSTM_CLK_PERIOD_NS     (1000000000 / `OSTM_CLK_FREQ_HZ)
// Least pulse spacing the output path needs, and latest acceptable drive after the trigger pulse
`define OSTM_REQ_SPACING_NS    32'h0000_07D0
`define OSTM_LATE_LIMIT_NS     32'h0000_4E20

`endif

// ==== ostm_pkg.sv ====
// Types shared by the output-side sync timing monitor.
// Assumes ostm_cfg.svh holds every numeric constant.
`include "ostm_cfg.svh"

package ostm_pkg;

  // Cycle tracking between trigger and output drive
  typedef enum logic [0:0] {
    CYC_IDLE,
    CYC_BUSY
  } ostm_cyc_t;

  // Measured timing entries, all in nanoseconds
  typedef struct packed {
    logic [31:0] shift;
    logic [31:0] min_cycle;
    logic [31:0] calc_copy;
    logic [31:0] min_delay;
    logic [31:0] max_delay;
  } ostm_meas_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ostm_apb_req_t;

endpackage : ostm_pkg

// ==== ostm_output_sync_monitor.sv ====
// Output-side synchronization timing monitor with APB register access and one interrupt line.
// Assumes all inputs synchronous to CLK_IN; pulse inputs are high for one clock per event.
`timescale 1ns/1ps
`include "ostm_cfg.svh"

// Functional notes
// - Capability word bits 2-3 read 01: shared-time sync supported.
// - Capability bits 4-5 read 10: output shift uses second sync pulse.
// - Capability bit 14 reads 1: timing values measured via command entry.
// - Read-only minimum cycle time in ns, reset 250000.
// - Read-only calc-and-copy time: least spacing between both sync pulses.
// - Read-only minimum delay from second pulse to outputs driven.
// - Command write 1 starts measurement, 0 stops; resets to 0.
// - While measuring, timing entries keep largest values seen.
// - Starting a new measurement clears previously captured maxima.
// - Read-only maximum delay from second pulse to outputs driven.
// - Counter of buffer-manager events missed while running, shared-time only.
// - Counter of cycles overrun or started too early while running.
// - Counter of too-short spacing between first and second pulses.
// - Flag set when last cycle drove outputs too late.
// - Sync mode: 0 free run, 1 buffer-manager, 2 first, 3 second pulse.
// - Shift time reports delay from first pulse to outputs driven.
module ostm_output_sync_monitor (
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        FIRST_SYNC_PULSE_IN,
  input  wire logic        SECOND_SYNC_PULSE_IN,
  input  wire logic        BUFFER_MANAGER_EVENT_IN,
  input  wire logic        OUTPUTS_DRIVEN_IN,
  input  wire logic        RUNNING_STATE_IN,
  output logic      [1:0]  SYNC_MODE_OUT,
  output logic             MEASURE_ACTIVE_OUT,
  output logic             IRQ_OUT
);

  localparam logic [31:0] TICK_NS = 32'(`OSTM_CLK_PERIOD_NS);
  localparam int          NCNT    = 3;

  // Saturating nanosecond advance; a stalled link must not wrap into a small time
  function automatic logic [31:0] ostm_sat_add(input logic [31:0] v);
    if (v > (32'hFFFF_FFFF - TICK_NS)) begin
      return 32'hFFFF_FFFF;
    end
    return v + TICK_NS;
  endfunction : ostm_sat_add

  // Larger of two times; every running maximum goes through here
  function automatic logic [31:0] ostm_max(input logic [31:0] a, input logic [31:0] b);
    return (a > b) ? a : b;
  endfunction : ostm_max

  // Bus pins gathered into one request record
  ostm_pkg::ostm_apb_req_t req;
  assign req = '{psel: PSEL_IN, penable: PENABLE_IN, pwrite: PWRITE_IN, paddr: PADDR_IN, pwdata: PWDATA_IN};

  // Register state
  logic [1:0]             mode_r,      mode_nxt;
  logic [15:0]            cmd_r,       cmd_nxt;
  logic [3:0]             mask_r,      mask_nxt;
  logic [3:0]             st_r,        st_nxt;
  logic [31:0]            prdata_r,    prdata_nxt;
  logic                   pready_r,    pready_nxt;
  logic                   pslverr_r,   pslverr_nxt;
  logic                   irq_r,       irq_nxt;
  ostm_pkg::ostm_meas_t   meas_r,      meas_nxt;
  logic                   sync_err_r,  sync_err_nxt;
  ostm_pkg::ostm_cyc_t    cyc_r,       cyc_nxt;
  logic [31:0]            t0_r,        t0_nxt;
  logic [31:0]            t1_r,        t1_nxt;
  logic [31:0]            tc_r,        tc_nxt;
  logic                   bm_seen_r,   bm_seen_nxt;
  logic                   run_d_r,     run_d_nxt;
  logic [15:0]            cnt_r [NCNT];

  // Decoded strobes and events
  logic        wr_acc;
  logic        dc_mode;
  logic        cyc_start;
  logic        out_evt;
  logic        run_rise;
  logic        meas_start;
  logic [31:0] delay_ref;
  logic        late;
  logic [3:0]  evt;
  logic [3:0]  w1c;
  logic [31:0] rd_val;
  logic        rd_hit;

  // Elapsed-time views of the three timers
  logic [31:0] el0;
  logic [31:0] el1;
  logic [31:0] elc;

  // Write takes effect only at the access edge with ready high
  assign wr_acc     = req.psel & req.penable & req.pwrite & pready_r;
  assign dc_mode    = mode_r[1];
  assign cyc_start  = dc_mode ? FIRST_SYNC_PULSE_IN : BUFFER_MANAGER_EVENT_IN;
  assign out_evt    = OUTPUTS_DRIVEN_IN & (cyc_r == ostm_pkg::CYC_BUSY);
  // Delayed copy resets low, so a high level at reset release counts as entry
  assign run_rise   = RUNNING_STATE_IN & ~run_d_r;
  // Start edge only: rewriting 1 while measuring keeps the maxima
  assign meas_start = wr_acc & (req.paddr == `OSTM_ADDR_COMMAND) & (req.pwdata[15:0] == 16'h0001)
                      & (cmd_r != 16'h0001);
  // Elapsed time including the current clock; the registered timers lag one tick,
  // so every comparison and capture uses these instead
  assign el0        = ostm_sat_add(t0_r);
  assign el1        = ostm_sat_add(t1_r);
  assign elc        = ostm_sat_add(tc_r);
  // Second-pulse mode measures delay from the second pulse, otherwise from the first
  assign delay_ref  = (mode_r == `OSTM_MODE_SECOND_SYNC) ? el1 : el0;
  assign late       = dc_mode & (delay_ref > `OSTM_LATE_LIMIT_NS);

  // Cycle events feeding counters and status
  assign evt[`OSTM_EVT_MISSED]   = RUNNING_STATE_IN & dc_mode & FIRST_SYNC_PULSE_IN
                                   & ~bm_seen_r & ~BUFFER_MANAGER_EVENT_IN;
  assign evt[`OSTM_EVT_OVERRUN]  = RUNNING_STATE_IN & cyc_start & (cyc_r == ostm_pkg::CYC_BUSY);
  assign evt[`OSTM_EVT_SHORT]    = dc_mode & SECOND_SYNC_PULSE_IN & (el0 < `OSTM_REQ_SPACING_NS);
  // Rising edge only, so a lasting error raises one status event
  assign evt[`OSTM_EVT_SYNC_ERR] = sync_err_nxt & ~sync_err_r;

  // Register read mux, evaluated in the setup phase
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (req.paddr)
      `OSTM_ADDR_SYNC_MODE:  rd_val = {30'h0000_0000, mode_r};
      `OSTM_ADDR_CAPS:       rd_val = {16'h0000, `OSTM_CAPS_VALUE};
      `OSTM_ADDR_SHIFT:      rd_val = meas_r.shift;
      `OSTM_ADDR_MIN_CYCLE:  rd_val = meas_r.min_cycle;
      `OSTM_ADDR_CALC_COPY:  rd_val = meas_r.calc_copy;
      `OSTM_ADDR_MIN_DELAY:  rd_val = meas_r.min_delay;
      `OSTM_ADDR_COMMAND:    rd_val = {16'h0000, cmd_r};
      `OSTM_ADDR_MAX_DELAY:  rd_val = meas_r.max_delay;
      `OSTM_ADDR_MISSED:     rd_val = {16'h0000, cnt_r[0]};
      `OSTM_ADDR_OVERRUN:    rd_val = {16'h0000, cnt_r[1]};
      `OSTM_ADDR_SHORT:      rd_val = {16'h0000, cnt_r[2]};
      `OSTM_ADDR_SYNC_ERR:   rd_val = {31'h0000_0000, sync_err_r};
      `OSTM_ADDR_IRQ_STATUS: rd_val = {28'h000_0000, st_r};
      `OSTM_ADDR_IRQ_MASK:   rd_val = {28'h000_0000, mask_r};
      default:               rd_hit = 1'b0;
    endcase
  end

  // Bus slave and software-written registers; zero wait states, answer latched at setup
  always_comb begin
    mode_nxt    = mode_r;
    cmd_nxt     = cmd_r;
    mask_nxt    = mask_r;
    w1c         = 4'h0;
    pready_nxt  = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    // Answer computed at setup so read data stands through the access phase
    // Unmapped or unaligned addresses answer with an error and zero data
    if (req.psel & ~req.penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = ~rd_hit;
      prdata_nxt  = req.pwrite ? 32'h0000_0000 : rd_val;
    end
    if (wr_acc) begin
      case (req.paddr)
        `OSTM_ADDR_SYNC_MODE:  mode_nxt = req.pwdata[1:0];
        `OSTM_ADDR_COMMAND: begin
          // Only 0 and 1 are meaningful; other values leave the command alone
          if (req.pwdata[15:1] == 15'h0000) begin
            cmd_nxt = req.pwdata[15:0];
          end
        end
        `OSTM_ADDR_IRQ_MASK:   mask_nxt = req.pwdata[3:0];
        `OSTM_ADDR_IRQ_STATUS: w1c = req.pwdata[3:0];
        default: ;
      endcase
    end
    // Hardware set wins over a simultaneous write-one clear
    st_nxt  = (st_r & ~w1c) | evt;
    irq_nxt = |(st_nxt & mask_nxt);
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mode_r    <= `OSTM_RST_SYNC_MODE;
      cmd_r     <= `OSTM_RST_COMMAND;
      mask_r    <= 4'h0;
      st_r      <= 4'h0;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      cmd_r     <= cmd_nxt;
      mask_r    <= mask_nxt;
      st_r      <= st_nxt;
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Timers in ns since each pulse and since cycle start, plus cycle tracking
  always_comb begin
    t0_nxt      = FIRST_SYNC_PULSE_IN  ? 32'h0000_0000 : el0;
    t1_nxt      = SECOND_SYNC_PULSE_IN ? 32'h0000_0000 : el1;
    tc_nxt      = cyc_start ? 32'h0000_0000 : elc;
    run_d_nxt   = RUNNING_STATE_IN;
    bm_seen_nxt = bm_seen_r;
    // A buffer-manager event landing with the first pulse counts for the closing cycle
    if (FIRST_SYNC_PULSE_IN) begin
      bm_seen_nxt = 1'b0;
    end else if (BUFFER_MANAGER_EVENT_IN) begin
      bm_seen_nxt = 1'b1;
    end
    cyc_nxt = cyc_r;
    case (cyc_r)
      ostm_pkg::CYC_IDLE: begin
        if (cyc_start) begin
          cyc_nxt = ostm_pkg::CYC_BUSY;
        end
      end
      ostm_pkg::CYC_BUSY: begin
        // New trigger while busy restarts the cycle; overrun is flagged separately
        if (cyc_start) begin
          cyc_nxt = ostm_pkg::CYC_BUSY;
        end else if (OUTPUTS_DRIVEN_IN) begin
          cyc_nxt = ostm_pkg::CYC_IDLE;
        end
      end
      default: cyc_nxt = ostm_pkg::CYC_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      t0_r      <= 32'h0000_0000;
      t1_r      <= 32'h0000_0000;
      tc_r      <= 32'h0000_0000;
      run_d_r   <= 1'b0;
      bm_seen_r <= 1'b0;
      cyc_r     <= ostm_pkg::CYC_IDLE;
    end else begin
      t0_r      <= t0_nxt;
      t1_r      <= t1_nxt;
      tc_r      <= tc_nxt;
      run_d_r   <= run_d_nxt;
      bm_seen_r <= bm_seen_nxt;
      cyc_r     <= cyc_nxt;
    end
  end

  // Measured entries and per-cycle sync error
  always_comb begin
    meas_nxt     = meas_r;
    sync_err_nxt = sync_err_r;
    if (meas_start) begin
      // All five entries restart from zero, min cycle included
      meas_nxt.shift     = `OSTM_RST_MEAS;
      meas_nxt.min_cycle = `OSTM_RST_MEAS;
      meas_nxt.calc_copy = `OSTM_RST_MEAS;
      meas_nxt.min_delay = `OSTM_RST_MEAS;
      meas_nxt.max_delay = `OSTM_RST_MEAS;
    end else begin
      if (cmd_r[0] & dc_mode & SECOND_SYNC_PULSE_IN) begin
        meas_nxt.calc_copy = ostm_max(meas_r.calc_copy, el0);
      end
      if (out_evt) begin
        if (cmd_r[0]) begin
          meas_nxt.min_cycle = ostm_max(meas_r.min_cycle, elc);
          if (dc_mode) begin
            meas_nxt.shift     = ostm_max(meas_r.shift, el0);
            meas_nxt.min_delay = ostm_max(meas_r.min_delay, el1);
          end
        end
        // Maximum delay keeps growing even with measurement stopped
        if (dc_mode) begin
          meas_nxt.max_delay = ostm_max(meas_r.max_delay, el1);
        end
      end
    end
    // Flag reflects only the last cycle: rewritten at every output drive in modes 2 and 3
    if (out_evt & dc_mode) begin
      sync_err_nxt = late;
    // An overrun in shared-time mode also marks the cycle as failed
    end else if (evt[`OSTM_EVT_OVERRUN] & dc_mode) begin
      sync_err_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      meas_r.shift     <= `OSTM_RST_MEAS;
      meas_r.min_cycle <= `OSTM_RST_MIN_CYCLE;
      meas_r.calc_copy <= `OSTM_RST_MEAS;
      meas_r.min_delay <= `OSTM_RST_MEAS;
      meas_r.max_delay <= `OSTM_RST_MEAS;
      sync_err_r       <= 1'b0;
    end else begin
      meas_r           <= meas_nxt;
      sync_err_r       <= sync_err_nxt;
    end
  end

  // Saturating event counters; entry into running clears, an event in that cycle still counts
  generate
    // One counter for each of the first three event kinds (none for sync error), index matching the status bit
    for (genvar gi = 0; gi < NCNT; gi++) begin : g_cnt
      logic [15:0] cnt_nxt;
      always_comb begin
        cnt_nxt = cnt_r[gi];
        if (run_rise) begin
          cnt_nxt = {15'h0000, evt[gi]};
        // Saturation keeps a long fault burst from wrapping to a harmless small count
        end else if (evt[gi] && (cnt_r[gi] != 16'hFFFF)) begin
          cnt_nxt = cnt_r[gi] + 16'h0001;
        end
      end
      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          cnt_r[gi] <= `OSTM_RST_COUNT;
        end else begin
          cnt_r[gi] <= cnt_nxt;
        end
      end
    end
  endgenerate

  // Outputs straight from flip-flops
  // No decode logic sits between any register and its pin
  assign PRDATA_OUT         = prdata_r;
  assign PREADY_OUT         = pready_r;
  assign PSLVERR_OUT        = pslverr_r;
  assign SYNC_MODE_OUT      = mode_r;
  assign MEASURE_ACTIVE_OUT = cmd_r[0];
  assign IRQ_OUT            = irq_r;

endmodule : ostm_output_sync_monitor

// ==== ostm_chk_monitor.sv ====
// Concurrent checks on the monitor's APB and mode ports.
// Assumes binding to ostm_output_sync_monitor; one clock domain.
`timescale 1ns/1ps
`include "ostm_cfg.svh"
module ostm_chk (
  input wire logic        CLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic [1:0]  SYNC_MODE_OUT,
  input wire logic        MEASURE_ACTIVE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic       setup;
  logic       wr_acc;
  logic       cmd_wr;
  logic [1:0] wr_mode;
  // Phases as the slave sees them
  assign setup   = PSEL_IN && !PENABLE_IN;
  assign wr_acc  = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
  assign cmd_wr  = wr_acc && PADDR_IN == `OSTM_ADDR_COMMAND;
  assign wr_mode = PWDATA_IN[1:0];
  // Zero wait states, so ready follows setup exactly once
  chk_ready_after_setup: assert property (setup |=> PREADY_OUT) else $error("ready missing");
  chk_ready_has_cause: assert property (PREADY_OUT |-> $past(setup)) else $error("stray ready");
  chk_err_unmapped: assert property (setup && PADDR_IN > 8'h34 |=> PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped not refused");
  chk_err_mapped: assert property (setup && PADDR_IN <= 8'h34 |=> !PSLVERR_OUT) else $error("mapped refused");
  // Capability fields judged bit by bit, not from the packed constant
  chk_caps_fields: assert property (setup && !PWRITE_IN && PADDR_IN == `OSTM_ADDR_CAPS |=>
    PRDATA_OUT[3:2] == 2'b01 && PRDATA_OUT[5:4] == 2'b10 && PRDATA_OUT[14]) else $error("caps wrong");
  chk_mode_write: assert property (wr_acc && PADDR_IN == `OSTM_ADDR_SYNC_MODE |=>
    SYNC_MODE_OUT == $past(wr_mode)) else $error("mode not taken");
  chk_cmd_start: assert property (cmd_wr && PWDATA_IN == 32'h0000_0001 |=> MEASURE_ACTIVE_OUT)
    else $error("start lost");
  chk_cmd_stop: assert property (cmd_wr && PWDATA_IN == 32'h0000_0000 |=> !MEASURE_ACTIVE_OUT)
    else $error("stop lost");
  chk_cmd_hold: assert property (!cmd_wr |=> $stable(MEASURE_ACTIVE_OUT)) else $error("cmd moved");
endmodule : ostm_chk
bind ostm_output_sync_monitor ostm_chk ostm_chk_inst (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .SYNC_MODE_OUT(SYNC_MODE_OUT), .MEASURE_ACTIVE_OUT(MEASURE_ACTIVE_OUT));

// ==== ostm_master_model.sv ====
// Behavioural fieldbus master issuing sync pulses and cycle events.
// Assumes run_cycle is called right after a rising clk_in edge.
`timescale 1ns/1ps
module ostm_master_model (
  input  wire logic clk_in,
  output logic      first_out,
  output logic      second_out,
  output logic      bm_out,
  output logic      driven_out
);
  initial {first_out, second_out, bm_out, driven_out} = 4'h0;
  // One cycle: pulse spacing g clocks, drive l clocks later; d=0 leaves it unfinished
  task automatic run_cycle(input int g, input int l, input logic b, input logic d);
    first_out <= 1'b1;
    @(posedge clk_in);
    first_out <= 1'b0;
    repeat (g - 1) @(posedge clk_in);
    second_out <= 1'b1;
    @(posedge clk_in);
    second_out <= 1'b0;
    repeat (l - 1) @(posedge clk_in);
    driven_out <= d;
    bm_out <= b;
    @(posedge clk_in);
    driven_out <= 1'b0;
    bm_out <= 1'b0;
  endtask : run_cycle
endmodule : ostm_master_model

// ==== ostm_output_sync_monitor_test.sv ====
// Self-checking bench for the output sync timing monitor.
// Assumes zero-wait APB; the master model drives the pulse inputs.
`timescale 1ns/1ps
`include "ostm_cfg.svh"
module ostm_output_sync_monitor_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] rdata;
  logic        rdy, err, irq, act, first, second, bm, drv;
  logic [1:0]  mode;
  logic [32:0] q[$];
  logic [32:0] ex;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #20 clk = ~clk;
  ostm_output_sync_monitor ostm_output_sync_monitor_inst (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(rdata),
    .PREADY_OUT(rdy), .PSLVERR_OUT(err), .FIRST_SYNC_PULSE_IN(first), .SECOND_SYNC_PULSE_IN(second),
    .BUFFER_MANAGER_EVENT_IN(bm), .OUTPUTS_DRIVEN_IN(drv), .RUNNING_STATE_IN(run),
    .SYNC_MODE_OUT(mode), .MEASURE_ACTIVE_OUT(act), .IRQ_OUT(irq));
  ostm_master_model ostm_master_model_inst (.clk_in(clk), .first_out(first), .second_out(second),
    .bm_out(bm), .driven_out(drv));
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // One transfer, then an idle cycle so no strobe is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    q.push_back(e);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0000_0000, {1'b0, v});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0_0000_0000);
  endtask : wr
  task automatic irq_is(input logic e);
    @(negedge clk);
    check({32'h0000_0000, irq}, {32'h0000_0000, e});
    @(posedge clk);
  endtask : irq_is
  task automatic cyc_run(input int g, input int l, input logic b, input logic d);
    ostm_master_model_inst.run_cycle(g, l, b, d);
  endtask : cyc_run
  // Oldest note is matched against each completed transfer; writes compare the error bit only
  always @(posedge clk) begin
    if (rdy === 1'b1) begin
      ex = q.pop_front();
      check({err, pwr ? ex[31:0] : rdata}, ex);
    end
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h800ba18c));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset image of every mapped word
    for (int i = 0; i < 14; i++)
      rd(8'(i * 4), i == 0 ? 32'h0000_0001 : i == 1 ? 32'h0000_4027 : i == 3 ? 32'h0003_D090 : 32'h0000_0000);
    wr(`OSTM_ADDR_MIN_CYCLE, $urandom);
    rd(`OSTM_ADDR_MIN_CYCLE, 32'h0003_D090);
    apb(1'b0, 8'h38 + 8'($urandom_range(49) * 4), 32'h0000_0000, {1'b1, 32'h0000_0000});
    for (int m = 0; m < 4; m++) begin
      wr(`OSTM_ADDR_SYNC_MODE, 32'(m));
      rd(`OSTM_ADDR_SYNC_MODE, 32'(m));
      check({31'h0000_0000, mode}, 33'(m));
    end
    wr(`OSTM_ADDR_COMMAND, 32'h0000_0001);
    rd(`OSTM_ADDR_MIN_CYCLE, 32'h0000_0000);
    wr(`OSTM_ADDR_COMMAND, 32'h0000_0005);
    rd(`OSTM_ADDR_COMMAND, 32'h0000_0001);
    check({32'h0000_0000, act}, 33'h0_0000_0001);
    // Two measured cycles: entries keep the larger figures
    cyc_run(60, 5, 1'b1, 1'b1);
    cyc_run(60, 8, 1'b1, 1'b1);
    rd(`OSTM_ADDR_SHIFT, 32'h0000_0AA0);
    rd(`OSTM_ADDR_CALC_COPY, 32'h0000_0960);
    rd(`OSTM_ADDR_MIN_DELAY, 32'h0000_0140);
    rd(`OSTM_ADDR_MAX_DELAY, 32'h0000_0140);
    wr(`OSTM_ADDR_COMMAND, 32'h0000_0000);
    check({32'h0000_0000, act}, 33'h0_0000_0000);
    wr(`OSTM_ADDR_COMMAND, 32'h0000_0001);
    rd(`OSTM_ADDR_SHIFT, 32'h0000_0000);
    // Short spacing and a late drive raise masked status, then the line
    cyc_run(3, 5, 1'b1, 1'b1);
    rd(`OSTM_ADDR_SHORT, 32'h0000_0001);
    cyc_run(60, 520, 1'b1, 1'b1);
    rd(`OSTM_ADDR_SYNC_ERR, 32'h0000_0001);
    cyc_run(60, 5, 1'b1, 1'b1);
    rd(`OSTM_ADDR_SYNC_ERR, 32'h0000_0000);
    irq_is(1'b0);
    wr(`OSTM_ADDR_IRQ_MASK, 32'h0000_0004);
    irq_is(1'b1);
    wr(`OSTM_ADDR_IRQ_STATUS, 32'h0000_000F);
    irq_is(1'b0);
    rd(`OSTM_ADDR_IRQ_STATUS, 32'h0000_0000);
    // Running: one missed event, one overrun, then cleared on re-entry
    run <= 1'b1;
    cyc_run(60, 5, 1'b1, 1'b1);
    cyc_run(60, 5, 1'b0, 1'b1);
    cyc_run(60, 5, 1'b1, 1'b0);
    cyc_run(60, 5, 1'b1, 1'b1);
    rd(`OSTM_ADDR_MISSED, 32'h0000_0001);
    rd(`OSTM_ADDR_OVERRUN, 32'h0000_0001);
    run <= 1'b0;
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    rd(`OSTM_ADDR_MISSED, 32'h0000_0000);
    summarize();
  end
endmodule : ostm_output_sync_monitor_test
